// file: hdl/plt_top.sv
// position list processor: two lists, trigger level and speed setpoint
`timescale 1ns/100ps
`include "plt_consts.svh"
module plt_top
   import plt_pkg::*;
#(
   parameter int POS_SCALE = 1, // internal increments per user unit
   parameter int VEL_SCALE = 1 // internal speed per user unit
) (
   input wire logic mclk, // 125 MHz controller clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic par_wr, // parameter write strobe
   input wire logic par_rd, // parameter read strobe
   input wire logic [15:0] par_idx, // parameter index
   input wire logic [7:0] par_sidx, // parameter subindex
   input wire logic [31:0] par_wdata, // write data
   output logic [31:0] par_rdata, // read data, registered
   output logic par_ack, // access done, one cycle
   output logic par_err, // access refused, one cycle
   input wire logic [31:0] act_pos, // actual axis position, internal units
   output logic trig_out, // trigger output, low when open
   output logic [31:0] spd_set, // speed setpoint, internal units
   output logic spd_stb // new speed setpoint, one cycle
);
   plt_mem_if mif ();
   plt_list_mem u_mem (.mclk(mclk), .rst_n(rst_n), .mif(mif));

   plt_state_t state_reg;
   logic [1:0] sel_reg;
   logic run_list_reg; // list in use, 0 first, 1 second
   logic [5:0] cur_reg;
   logic [5:0] bgn1_reg, end1_reg, bgn2_reg, end2_reg;
   logic [15:0] act_reg;
   logic err_reg, quit_reg;
   logic [31:0] prev_pos_reg;
   logic trig_reg, spd_stb_reg;
   logic [31:0] spd_reg, rdata_reg;
   logic ack_reg, err_out_reg;

   // scale a user-unit value into internal units
   function automatic logic [31:0] usr_to_int(input logic [31:0] v, input int s);
      logic [63:0] p;
      p = $signed(v) * s;
      return p[31:0];
   endfunction

   // decode of the access
   logic reg_hit, l1_hit, l2_hit, ent_hit, sel_wr, run_act;
   logic [15:0] ent_off;
   logic ent_list;
   logic [5:0] ent_idx, fin_cur, bgn_new, end_new;
   assign reg_hit = (par_idx == `PLT_REG_IDX);
   assign l1_hit = (par_idx >= `PLT_L1_BASE) && (par_idx < `PLT_L1_BASE + 16'(`PLT_ENTRIES));
   assign l2_hit = (par_idx >= `PLT_L2_BASE) && (par_idx < `PLT_L2_BASE + 16'(`PLT_ENTRIES));
   assign ent_hit = l1_hit || l2_hit;
   assign ent_list = l2_hit;
   assign ent_off = par_idx - (l2_hit ? `PLT_L2_BASE : `PLT_L1_BASE);
   assign ent_idx = ent_off[5:0];
   assign sel_wr = par_wr && reg_hit && (par_sidx == `PLT_SIDX_SELECT);
   assign run_act = (state_reg == PLT_RUN);
   assign fin_cur = run_list_reg ? end2_reg : end1_reg;
   assign bgn_new = (par_wdata[1:0] == `PLT_SEL_L2) ? bgn2_reg : bgn1_reg;
   assign end_new = (par_wdata[1:0] == `PLT_SEL_L2) ? end2_reg : end1_reg;

   // edits of the list in use are refused while it runs
   logic ent_locked;
   assign ent_locked = run_act && (ent_list == run_list_reg);
   assign mif.wr_en = par_wr && ent_hit && !ent_locked
                      && (par_sidx >= `PLT_ESIDX_TYPE) && (par_sidx <= `PLT_ESIDX_VEL)
                      && !((par_sidx == `PLT_ESIDX_TYPE) && (ent_idx != 6'h00));
   assign mif.wr_list = ent_list;
   assign mif.wr_idx = ent_idx;
   assign mif.wr_sidx = par_sidx;
   assign mif.wr_data = par_wdata;
   assign mif.sw_list = ent_list;
   assign mif.sw_idx = ent_idx;
   assign mif.pr_list = run_list_reg;
   assign mif.pr_idx = cur_reg;

   // match when the axis reaches or crosses the entry position
   logic [31:0] tgt_int;
   logic hit, fire, is_sig, sel_ok;
   assign tgt_int = usr_to_int(mif.pr_entry.pos, POS_SCALE);
   assign hit = (act_pos == tgt_int)
                || (($signed(prev_pos_reg) < $signed(tgt_int)) && ($signed(act_pos) > $signed(tgt_int)))
                || (($signed(prev_pos_reg) > $signed(tgt_int)) && ($signed(act_pos) < $signed(tgt_int)));
   assign fire = run_act && hit && !sel_wr;
   // the list type is one value for the whole list
   assign is_sig = (mif.pr_type == `PLT_TYPE_SIG);
   assign sel_ok = (par_wdata[15:2] == 14'h0000) && (par_wdata[1:0] != 2'h3)
                   && ((par_wdata[1:0] == `PLT_SEL_NONE) || (bgn_new < end_new));

   // previous axis position for crossing detection, passive observer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) prev_pos_reg <= 32'h0000_0000;
      else prev_pos_reg <= act_pos;
   end

   // processing state, list in use and current entry
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PLT_IDLE;
         sel_reg <= `PLT_SEL_NONE;
         run_list_reg <= 1'b0;
         cur_reg <= `PLT_RST_START;
         quit_reg <= 1'b0;
         err_reg <= 1'b0;
      end else if (sel_wr) begin
         // any selection first deactivates the current list
         if (!sel_ok) begin
            state_reg <= PLT_IDLE;
            sel_reg <= `PLT_SEL_NONE;
            err_reg <= 1'b1;
         end else if (par_wdata[1:0] == `PLT_SEL_NONE) begin
            state_reg <= PLT_IDLE;
            sel_reg <= `PLT_SEL_NONE;
            err_reg <= 1'b0;
         end else begin
            // start at the kept start entry
            state_reg <= PLT_RUN;
            sel_reg <= par_wdata[1:0];
            run_list_reg <= (par_wdata[1:0] == `PLT_SEL_L2);
            cur_reg <= bgn_new;
            err_reg <= 1'b0;
         end
         quit_reg <= 1'b0;
      end else begin
         case (state_reg)
            PLT_RUN: begin
               if (fire) begin
                  // stop once the finish entry has been handled
                  if (cur_reg >= fin_cur) begin
                     state_reg <= PLT_DONE;
                     quit_reg <= 1'b1;
                  end else begin
                     cur_reg <= cur_reg + 6'h01;
                  end
               end
            end
            PLT_IDLE, PLT_DONE: ;
            default: state_reg <= PLT_IDLE;
         endcase
      end
   end

   // trigger level from signal lists only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) trig_reg <= 1'b0;
      else if (fire && is_sig) trig_reg <= mif.pr_entry.sig;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         spd_reg <= 32'h0000_0000;
         spd_stb_reg <= 1'b0;
      end else begin
         spd_stb_reg <= fire && !is_sig;
         if (fire && !is_sig) spd_reg <= usr_to_int(mif.pr_entry.vel, VEL_SCALE);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) act_reg <= `PLT_RST_ACT;
      else if (sel_wr && sel_ok && (par_wdata[1:0] != `PLT_SEL_NONE)) act_reg <= `PLT_ACT_NONE;
      else if (fire) act_reg <= {10'h000, cur_reg};
      else if (par_wr && reg_hit && (par_sidx == `PLT_SIDX_ACT)) act_reg <= par_wdata[15:0];
   end

   // start and finish numbers, kept across stops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bgn1_reg <= `PLT_RST_START;
         end1_reg <= `PLT_RST_END;
         bgn2_reg <= `PLT_RST_START;
         end2_reg <= `PLT_RST_END;
      end else if (par_wr && reg_hit) begin
         case (par_sidx)
            `PLT_SIDX_END1: end1_reg <= par_wdata[5:0];
            `PLT_SIDX_BGN2: bgn2_reg <= par_wdata[5:0];
            `PLT_SIDX_END2: end2_reg <= par_wdata[5:0];
            default: ;
         endcase
      end
   end

   // read data, acknowledge and refusal
   logic [31:0] rd_next;
   logic bad_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      bad_next = 1'b0;
      if (reg_hit) begin
         case (par_sidx)
            `PLT_SIDX_SELECT: rd_next = {30'h0, sel_reg};
            `PLT_SIDX_STATE: begin
               rd_next[`PLT_BIT_ERR] = err_reg;
               rd_next[`PLT_BIT_QUIT] = quit_reg;
               rd_next[1:0] = run_act ? sel_reg : `PLT_SEL_NONE;
            end
            `PLT_SIDX_CNT1, `PLT_SIDX_CNT2: rd_next = {16'h0000, `PLT_CNT_VAL};
            `PLT_SIDX_BGN1: rd_next = {26'h0, bgn1_reg};
            `PLT_SIDX_END1: rd_next = {26'h0, end1_reg};
            `PLT_SIDX_BGN2: rd_next = {26'h0, bgn2_reg};
            `PLT_SIDX_END2: rd_next = {26'h0, end2_reg};
            `PLT_SIDX_ACT: rd_next = {{16{act_reg[15]}}, act_reg};
            default: bad_next = 1'b1;
         endcase
         if (par_wr && (par_sidx == `PLT_SIDX_STATE || par_sidx == `PLT_SIDX_CNT1
             || par_sidx == `PLT_SIDX_CNT2 || par_sidx == `PLT_SIDX_BGN1)) bad_next = 1'b1;
         if (sel_wr && !sel_ok) bad_next = 1'b1;
      end else if (ent_hit) begin
         case (par_sidx)
            `PLT_ESIDX_TYPE: rd_next = {30'h0, mif.sw_type};
            `PLT_ESIDX_POS: rd_next = mif.sw_entry.pos;
            `PLT_ESIDX_SIG: rd_next = {31'h0, mif.sw_entry.sig};
            `PLT_ESIDX_VEL: rd_next = mif.sw_entry.vel;
            default: bad_next = 1'b1;
         endcase
         if (par_wr && (ent_locked || (par_sidx == `PLT_ESIDX_TYPE && ent_idx != 6'h00)))
            bad_next = 1'b1;
      end else begin
         bad_next = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         err_out_reg <= 1'b0;
      end else begin
         ack_reg <= par_wr || par_rd;
         err_out_reg <= (par_wr || par_rd) && bad_next;
         if (par_rd) rdata_reg <= bad_next ? 32'h0000_0000 : rd_next;
      end
   end

   assign par_rdata = rdata_reg;
   assign par_ack = ack_reg;
   assign par_err = err_out_reg;
   assign trig_out = trig_reg;
   assign spd_set = spd_reg;
   assign spd_stb = spd_stb_reg;

   // ************************************
   // assertions
   // ************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_trig_src;
      trig_out != $past(trig_out) |-> $past(fire) && $past(is_sig);
   endproperty
   a_trig_src: assert property (p_trig_src) else $error("trigger moved without signal match");

   property p_spd_apply;
      fire && !is_sig |=> spd_stb && spd_set == $past(usr_to_int(mif.pr_entry.vel, VEL_SCALE));
   endproperty
   a_spd_apply: assert property (p_spd_apply) else $error("speed not applied at match");

   property p_advance;
      fire && (cur_reg < fin_cur) |=> cur_reg == $past(cur_reg) + 6'h01
                                      && act_reg == {10'h000, $past(cur_reg)};
   endproperty
   a_advance: assert property (p_advance) else $error("entry not advanced");

   property p_finish;
      fire && (cur_reg >= fin_cur) |=> state_reg == PLT_DONE && quit_reg ##1 !spd_stb;
   endproperty
   a_finish: assert property (p_finish) else $error("no stop after finish entry");

   property p_halt;
      sel_wr && par_wdata == 32'h0 |=> state_reg == PLT_IDLE && !spd_stb;
   endproperty
   a_halt: assert property (p_halt) else $error("deselect did not halt");

   property p_switch;
      run_act && sel_wr && sel_ok && par_wdata[1:0] != `PLT_SEL_NONE
         |=> run_act && sel_reg == $past(par_wdata[1:0]) && cur_reg == $past(bgn_new);
   endproperty
   a_switch: assert property (p_switch) else $error("list switch failed");

   property p_act_none;
      sel_wr && sel_ok && par_wdata[1:0] != `PLT_SEL_NONE |=> act_reg == `PLT_ACT_NONE;
   endproperty
   a_act_none: assert property (p_act_none) else $error("last entry not cleared");

   property p_locked;
      par_wr && ent_hit && ent_locked |-> !mif.wr_en ##1 par_err;
   endproperty
   a_locked: assert property (p_locked) else $error("active list edited");

   property p_count;
      par_rd && reg_hit && par_sidx == `PLT_SIDX_CNT1 |=> par_ack && par_rdata == 32'h40;
   endproperty
   a_count: assert property (p_count) else $error("entry count wrong");

   c_sig_fire: cover property (fire && is_sig);
   c_spd_fire: cover property (fire && !is_sig);
   c_done: cover property (state_reg == PLT_RUN ##1 state_reg == PLT_DONE);
endmodule

// file: hdl/plt_consts.svh
// constants for the position list trigger block
`ifndef PLT_CONSTS_SVH
`define PLT_CONSTS_SVH
`define PLT_ENTRIES 64
`define PLT_IDX_W 6
`define PLT_LAST_IDX 6'h3f
`define PLT_REG_IDX 16'h002c
`define PLT_SIDX_SELECT 8'h01
`define PLT_SIDX_STATE 8'h02
`define PLT_SIDX_CNT1 8'h04
`define PLT_SIDX_BGN1 8'h06
`define PLT_SIDX_END1 8'h07
`define PLT_SIDX_CNT2 8'h0c
`define PLT_SIDX_BGN2 8'h0e
`define PLT_SIDX_END2 8'h0f
`define PLT_SIDX_ACT 8'h12
`define PLT_L1_BASE 16'h044c
`define PLT_L2_BASE 16'h04b0
`define PLT_ESIDX_TYPE 8'h01
`define PLT_ESIDX_POS 8'h02
`define PLT_ESIDX_SIG 8'h03
`define PLT_ESIDX_VEL 8'h04
`define PLT_TYPE_SIG 2'h1
`define PLT_TYPE_SPD 2'h2
`define PLT_SEL_NONE 2'h0
`define PLT_SEL_L1 2'h1
`define PLT_SEL_L2 2'h2
`define PLT_BIT_ERR 15
`define PLT_BIT_QUIT 14
`define PLT_RST_START 6'h00
`define PLT_RST_END 6'h3f
`define PLT_RST_ACT 16'h0000
`define PLT_ACT_NONE 16'hffff
`define PLT_CNT_VAL 16'h0040
`endif

// file: hdl/plt_pkg.sv
// types shared by the position list trigger block
package plt_pkg;
   typedef enum logic [2:0] {
      PLT_IDLE = 3'b001,
      PLT_RUN = 3'b010,
      PLT_DONE = 3'b100
   } plt_state_t;
   typedef struct packed {
      logic [31:0] pos;
      logic sig;
      logic [31:0] vel;
   } plt_entry_t;
endpackage

// file: hdl/plt_mem_if.sv
// carrier between the list processor and the list storage
`timescale 1ns/100ps
interface plt_mem_if;
   import plt_pkg::*;
   logic wr_en;
   logic wr_list;
   logic [5:0] wr_idx;
   logic [7:0] wr_sidx;
   logic [31:0] wr_data;
   logic pr_list;
   logic [5:0] pr_idx;
   plt_entry_t pr_entry;
   logic [1:0] pr_type;
   logic sw_list;
   logic [5:0] sw_idx;
   plt_entry_t sw_entry;
   logic [1:0] sw_type;
   modport ctrl (output wr_en, wr_list, wr_idx, wr_sidx, wr_data, pr_list, pr_idx,
                 sw_list, sw_idx, input pr_entry, pr_type, sw_entry, sw_type);
   modport mem (input wr_en, wr_list, wr_idx, wr_sidx, wr_data, pr_list, pr_idx,
                sw_list, sw_idx, output pr_entry, pr_type, sw_entry, sw_type);
endinterface

// file: hdl/plt_list_mem.sv
// storage for the two position lists and their list types
`timescale 1ns/100ps
`include "plt_consts.svh"
module plt_list_mem
   import plt_pkg::*;
#(
   parameter int ENTRIES = `PLT_ENTRIES
) (
   input wire logic mclk, // controller clock
   input wire logic rst_n, // asynchronous reset, active low
   plt_mem_if.mem mif // write and read ports
);
   logic [31:0] pos_mem [2][ENTRIES];
   logic sig_mem [2][ENTRIES];
   logic [31:0] vel_mem [2][ENTRIES];
   logic [1:0] type_reg [2];

   // two lists of entries
   // entry fields and list types, one write port
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int l = 0; l < 2; l++) begin
            type_reg[l] <= `PLT_TYPE_SIG;
            for (int e = 0; e < ENTRIES; e++) begin
               pos_mem[l][e] <= 32'h0000_0000;
               sig_mem[l][e] <= 1'b0;
               vel_mem[l][e] <= 32'h0000_0000;
            end
         end
      end else if (mif.wr_en) begin
         case (mif.wr_sidx)
            `PLT_ESIDX_TYPE: type_reg[mif.wr_list] <= mif.wr_data[1:0];
            `PLT_ESIDX_POS: pos_mem[mif.wr_list][mif.wr_idx] <= mif.wr_data;
            `PLT_ESIDX_SIG: sig_mem[mif.wr_list][mif.wr_idx] <= mif.wr_data[0];
            `PLT_ESIDX_VEL: vel_mem[mif.wr_list][mif.wr_idx] <= mif.wr_data;
            default: ;
         endcase
      end
   end

   // processor read port and software read port
   assign mif.pr_entry = '{pos: pos_mem[mif.pr_list][mif.pr_idx],
                           sig: sig_mem[mif.pr_list][mif.pr_idx],
                           vel: vel_mem[mif.pr_list][mif.pr_idx]};
   assign mif.pr_type = type_reg[mif.pr_list];
   assign mif.sw_entry = '{pos: pos_mem[mif.sw_list][mif.sw_idx],
                           sig: sig_mem[mif.sw_list][mif.sw_idx],
                           vel: vel_mem[mif.sw_list][mif.sw_idx]};
   assign mif.sw_type = type_reg[mif.sw_list];
endmodule

// file: dv/plt_axis_model.sv
// partner model: axis position source, trigger and speed consumer
`timescale 1ns/100ps
module plt_axis_model (
   input wire logic mclk, // controller clock
   input wire logic rst_n, // reset, active low
   input wire logic trig_out, // trigger level from the block
   input wire logic spd_stb, // speed setpoint strobe
   output logic [31:0] act_pos, // axis position fed back
   output int n_stb, // speed strobes seen
   output int n_edge // trigger level changes seen
);
   logic trig_seen_reg;
   initial begin
      act_pos = 32'h0;
      n_stb = 0;
      n_edge = 0;
   end
   // count speed strobes and trigger level changes
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trig_seen_reg <= 1'b0;
      end else begin
         trig_seen_reg <= trig_out;
         if (trig_out !== trig_seen_reg) n_edge <= n_edge + 1;
         if (spd_stb === 1'b1) n_stb <= n_stb + 1;
      end
   end
   // ****************************************
   // axis travel
   // ****************************************
   // travel monotonic, independent of lists
   // close spacing kept short on purpose, block answers every cycle
   task automatic move_to(input logic [31:0] target, input logic [31:0] step);
      while (act_pos !== target) begin
         @(negedge mclk);
         if ($signed(target) > $signed(act_pos))
            act_pos = ($signed(target - act_pos) > $signed(step)) ? act_pos + step : target;
         else
            act_pos = ($signed(act_pos - target) > $signed(step)) ? act_pos - step : target;
      end
      // settle: match edge plus answer edge
      repeat (3) @(negedge mclk);
   endtask
endmodule

// file: dv/tb_position_list_trigger.sv
// testbench for the position list trigger block
`timescale 1ns/100ps
`include "plt_consts.svh"
module tb_position_list_trigger;
   import plt_pkg::*;
   localparam logic [15:0] ri = `PLT_REG_IDX;
   localparam logic [15:0] l1 = `PLT_L1_BASE;
   localparam logic [15:0] l2 = `PLT_L2_BASE;
   typedef struct packed {
      logic wr;
      logic [15:0] idx;
      logic [7:0] sidx;
      logic [31:0] wd;
      logic [31:0] exp;
      logic err;
   } plt_row_t;
   logic mclk, rst_n, par_wr, par_rd, par_ack, par_err, trig_out, spd_stb, rd_err;
   logic [15:0] par_idx;
   logic [7:0] par_sidx;
   logic [31:0] par_wdata, par_rdata, act_pos, spd_set, rd_val;
   int n_stb, n_edge, n_mismatch, samples_checked, s0;
   logic [31:0] pos_tab [4] = '{32'h0a, 32'h32, 32'h78, 32'hc8};
   logic [31:0] stop_tab [4] = '{32'h1e, 32'h3c, 32'h82, 32'hd2};
   logic sig_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic [31:0] l2_pos [3] = '{32'h190, 32'h12c, 32'hfa};
   logic [31:0] l2_vel [3] = '{32'h63, 32'h1f4, 32'h2bc};
   // reset-state reads, refused writes and one accepted END2 write read back, data ignored on writes
   plt_row_t rows [17] = '{
      '{1'b0, ri, 8'h01, 32'h0, 32'h0, 1'b0}, '{1'b0, ri, 8'h02, 32'h0, 32'h0, 1'b0},
      '{1'b0, ri, 8'h04, 32'h0, 32'h40, 1'b0}, '{1'b0, ri, 8'h06, 32'h0, 32'h0, 1'b0},
      '{1'b0, ri, 8'h07, 32'h0, 32'h3f, 1'b0}, '{1'b0, ri, 8'h12, 32'h0, 32'h0, 1'b0},
      '{1'b0, ri, 8'h0c, 32'h0, 32'h40, 1'b0}, '{1'b0, ri, 8'h0e, 32'h0, 32'h0, 1'b0},
      '{1'b0, ri, 8'h0f, 32'h0, 32'h3f, 1'b0}, '{1'b0, ri, 8'h03, 32'h0, 32'h0, 1'b1},
      '{1'b1, ri, 8'h04, 32'h5, 32'h0, 1'b1}, '{1'b1, ri, 8'h06, 32'h5, 32'h0, 1'b1},
      '{1'b1, ri, 8'h02, 32'h5, 32'h0, 1'b1}, '{1'b1, l2 + 16'h1, 8'h01, 32'h2, 32'h0, 1'b1},
      '{1'b0, l1, 8'h01, 32'h0, 32'h1, 1'b0}, '{1'b1, ri, 8'h0f, 32'h3e, 32'h0, 1'b0},
      '{1'b0, ri, 8'h0f, 32'h0, 32'h3e, 1'b0}};

   plt_top plt_top_i (.mclk(mclk), .rst_n(rst_n), .par_wr(par_wr), .par_rd(par_rd),
      .par_idx(par_idx), .par_sidx(par_sidx), .par_wdata(par_wdata), .par_rdata(par_rdata),
      .par_ack(par_ack), .par_err(par_err), .act_pos(act_pos), .trig_out(trig_out),
      .spd_set(spd_set), .spd_stb(spd_stb));
   plt_axis_model plt_axis_model_i (.mclk(mclk), .rst_n(rst_n), .trig_out(trig_out),
      .spd_stb(spd_stb), .act_pos(act_pos), .n_stb(n_stb), .n_edge(n_edge));

   // 125 MHz clock
   always #4 mclk = ~mclk;
   // ****************************************
   // compare and access tasks
   // ****************************************
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle strobe, answer taken while the acknowledge pulse stands
   task automatic par_access(input logic w, input logic [15:0] i, input logic [7:0] s,
                             input logic [31:0] d);
      @(negedge mclk);
      par_wr = w;
      par_rd = !w;
      par_idx = i;
      par_sidx = s;
      par_wdata = d;
      @(negedge mclk);
      chk_bit(par_ack, 1'b1);
      rd_val = par_rdata;
      rd_err = par_err;
      par_wr = 1'b0;
      par_rd = 1'b0;
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                     input logic e);
      par_access(1'b1, i, s, d);
      chk_bit(rd_err, e);
   endtask
   task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
      par_access(1'b0, i, s, 32'h0);
      chk_val(rd_val, e);
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the whole run needs well under 3000 cycles
   initial begin
      repeat (10000) @(posedge mclk);
      n_mismatch++;
      print_verdict();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      par_wr = 1'b0;
      par_rd = 1'b0;
      par_idx = 16'h0;
      par_sidx = 8'h0;
      par_wdata = 32'h0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      chk_bit(trig_out, 1'b0);
      foreach (rows[k]) begin
         par_access(rows[k].wr, rows[k].idx, rows[k].sidx, rows[k].wd);
         chk_bit(rd_err, rows[k].err);
         if (!rows[k].wr) chk_val(rd_val, rows[k].exp);
      end
      $display("done: register table");
      // signal list 1, entries 0..3, crossings with step 7
      wr(l1, 8'h01, 32'h1, 1'b0);
      for (int n = 0; n < 4; n++) begin
         wr(l1 + 16'(n), 8'h02, pos_tab[n], 1'b0);
         wr(l1 + 16'(n), 8'h03, {31'h0, sig_tab[n]}, 1'b0);
      end
      wr(ri, 8'h07, 32'h3, 1'b0);
      wr(ri, 8'h01, 32'h1, 1'b0);
      rd(ri, 8'h02, 32'h1);
      rd(ri, 8'h12, 32'hffffffff);
      s0 = n_edge;
      for (int n = 0; n < 4; n++) begin
         plt_axis_model_i.move_to(stop_tab[n], 32'h7);
         chk_bit(trig_out, sig_tab[n]);
         rd(ri, 8'h12, 32'(n));
      end
      chk_val(32'(n_edge - s0), 32'h3);
      rd(ri, 8'h02, 32'h4000);
      $display("done: signal list");
      // speed list 2, descending travel, range 1..2
      wr(l2, 8'h01, 32'h2, 1'b0);
      for (int n = 0; n < 3; n++) begin
         wr(l2 + 16'(n), 8'h02, l2_pos[n], 1'b0);
         wr(l2 + 16'(n), 8'h04, l2_vel[n], 1'b0);
      end
      wr(ri, 8'h0e, 32'h1, 1'b0);
      wr(ri, 8'h0f, 32'h2, 1'b0);
      plt_axis_model_i.move_to(32'h1c2, 32'h14);
      s0 = n_stb;
      wr(ri, 8'h01, 32'h2, 1'b0);
      wr(l2 + 16'h1, 8'h02, 32'h12c, 1'b1);
      wr(l1 + 16'h1, 8'h02, 32'h32, 1'b0);
      plt_axis_model_i.move_to(32'h118, 32'h5);
      chk_val(spd_set, 32'h1f4);
      rd(ri, 8'h12, 32'h1);
      plt_axis_model_i.move_to(32'hf0, 32'h5);
      chk_val(spd_set, 32'h2bc);
      chk_val(32'(n_stb - s0), 32'h2);
      chk_bit(trig_out, 1'b1);
      rd(ri, 8'h02, 32'h4000);
      $display("done: speed list");
      // restart, switch and halt
      plt_axis_model_i.move_to(32'h0, 32'h14);
      wr(ri, 8'h01, 32'h1, 1'b0);
      rd(ri, 8'h12, 32'hffffffff);
      plt_axis_model_i.move_to(32'h3c, 32'h7);
      chk_bit(trig_out, 1'b0);
      wr(ri, 8'h01, 32'h2, 1'b0);
      rd(ri, 8'h02, 32'h2);
      wr(ri, 8'h01, 32'h0, 1'b0);
      rd(ri, 8'h02, 32'h0);
      plt_axis_model_i.move_to(32'h82, 32'h7);
      chk_bit(trig_out, 1'b0);
      $display("done: restart switch halt");
      // refused selections
      wr(ri, 8'h01, 32'h3, 1'b1);
      rd(ri, 8'h02, 32'h8000);
      wr(ri, 8'h0e, 32'h5, 1'b0);
      wr(ri, 8'h0f, 32'h5, 1'b0);
      wr(ri, 8'h01, 32'h2, 1'b1);
      wr(ri, 8'h01, 32'h0, 1'b0);
      rd(ri, 8'h02, 32'h0);
      rd(l1 + 16'h2, 8'h02, 32'h78);
      rd(l1 + 16'h1, 8'h03, 32'h0);
      rd(l2 + 16'h2, 8'h04, 32'h2bc);
      wr(ri, 8'h12, 32'h5, 1'b0);
      rd(ri, 8'h12, 32'h5);
      $display("done: refused selections");
      // reset in mid-run
      plt_axis_model_i.move_to(32'h0, 32'h14);
      wr(ri, 8'h01, 32'h1, 1'b0);
      plt_axis_model_i.move_to(32'h1e, 32'h7);
      chk_bit(trig_out, 1'b1);
      rst_n = 1'b0;
      @(negedge mclk);
      chk_bit(trig_out, 1'b0);
      chk_val(spd_set, 32'h0);
      rst_n = 1'b1;
      rd(ri, 8'h07, 32'h3f);
      rd(ri, 8'h12, 32'h0);
      rd(ri, 8'h01, 32'h0);
      $display("done: mid-run reset");
      print_verdict();
   end
endmodule
